/* File: rtl/dsg_regs.svh */
// register offsets, field positions, reset values of the deep-sleep clock gate block
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// register byte offsets
`define DSG_OFF_RUN_GATE 12'h100
`define DSG_OFF_DEEP_GATE 12'h120
`define DSG_OFF_CTRL 12'h140
`define DSG_OFF_STATE 12'h144
`define DSG_OFF_IRQ_STAT 12'h148
`define DSG_OFF_IRQ_MASK 12'h14C

// gate bit positions inside the gate registers
`define DSG_BIT_PWM 20
`define DSG_BIT_ADC0 16
`define DSG_BIT_WDOG 3
// leftover reset marker bit in the deep-sleep word
`define DSG_BIT_RST_MARK 6

// writable bits of a gate register
`define DSG_GATE_WMASK 32'h0011_0008
// documented whole-word reset value of the deep-sleep register
`define DSG_DEEP_RESET 32'h0000_0040
`define DSG_RUN_RESET 32'h0000_0000

// control register fields
`define DSG_CTRL_ACG_BIT 0
`define DSG_CTRL_RESET 32'h0000_0000

// state / interrupt register fields: unit index 0 pwm, 1 adc0, 2 watchdog
`define DSG_NUM_UNITS 3
`define DSG_STATE_DEEP_BIT 8
`define DSG_STATE_SRC_BIT 9

`endif

/* File: rtl/dsg_pkg.sv */
// types shared by the deep-sleep clock gate block
`default_nettype none
package dsg_pkg;

  // which register currently drives the unit clock enables
  typedef enum logic [1:0] {
    DSG_SRC_RUN = 2'b00,
    DSG_SRC_DEEP = 2'b01
  } dsg_src_t;

  // unit index inside the gated group
  typedef enum logic [1:0] {
    DSG_UNIT_PWM = 2'b00,
    DSG_UNIT_ADC0 = 2'b01,
    DSG_UNIT_WDOG = 2'b10
  } dsg_unit_t;

endpackage
`default_nettype wire

/* File: rtl/dsg_unit_gate.sv */
// one unit's clock enable and its bus fault on access while gated
`default_nettype none
module dsg_unit_gate (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // gate sources
  input wire logic run_bit_i,
  input wire logic deep_bit_i,
  input wire logic use_deep_i,
  // access toward the unit
  input wire logic access_i,
  // results
  output logic clk_en_o,
  output logic fault_o
);

  logic clk_en_q;
  logic fault_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_en_q <= 1'b0;
    end else begin
      clk_en_q <= use_deep_i ? deep_bit_i : run_bit_i;
    end
  end

  // fault judged against the enable actually applied this cycle
  // gated access faults
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= access_i & ~clk_en_q;
    end
  end

  assign clk_en_o = clk_en_q;
  assign fault_o = fault_q;

endmodule
`default_nettype wire

/* File: rtl/dsg_clock_gate.sv */
// deep-sleep clock gating register with unit enables, bus faults and interrupt
//
// Contract
// - set bit clocks unit, clear stops it
// - access to gated unit returns bus fault
// - gate bits reset to zero
// - word resets 0x40, marker bit resolved
// - register applies during deep-sleep only; here also only while the ctrl auto gating bit is set
// - bit 20 gates the modulator
// - bit 16 gates converter zero
// - bit 3 gates the watchdog
// - reserved bits read zero, writes ignored; deep word bit 6 reads one from reset until the first deep write
`include "dsg_regs.svh"
`default_nettype none
module dsg_clock_gate
  import dsg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // power mode from the power controller, same clock
  input wire logic deep_sleep_i,
  // accesses toward the units: 0 pwm, 1 adc0, 2 watchdog
  input wire logic [`DSG_NUM_UNITS-1:0] unit_access_i,
  // unit clock enables and bus fault answer
  output logic pwm_clk_en_o,
  output logic adc0_clk_en_o,
  output logic watchdog_gate_o,
  output logic bus_fault_o,
  // interrupt
  output logic irq_o
);

  localparam int NU = `DSG_NUM_UNITS;

  // gate bit of a unit inside a gate register word
  function automatic logic gate_bit(input logic [31:0] word, input dsg_unit_t unit);
    logic b;
    b = 1'b0;
    case (unit)
      DSG_UNIT_PWM: b = word[`DSG_BIT_PWM];
      DSG_UNIT_ADC0: b = word[`DSG_BIT_ADC0];
      DSG_UNIT_WDOG: b = word[`DSG_BIT_WDOG];
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  // address decode shared by the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
    return addr == ADDR_W'(off);
  endfunction

  // register state
  logic [31:0] run_gate_reg0_q;
  logic [31:0] deep_sleep_gate_reg0_q;
  logic rst_mark_q;
  logic auto_clock_gating_enable_q;
  logic [NU-1:0] irq_stat_q;
  logic [NU-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic bus_fault_q;
  dsg_src_t src_q;

  // per-unit results
  logic [NU-1:0] clk_en;
  logic [NU-1:0] fault;

  // decoded write strobes
  logic wr_run;
  logic wr_deep;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign wr_run = reg_wr_i & hit(reg_addr_i, `DSG_OFF_RUN_GATE);
  assign wr_deep = reg_wr_i & hit(reg_addr_i, `DSG_OFF_DEEP_GATE);
  assign wr_ctrl = reg_wr_i & hit(reg_addr_i, `DSG_OFF_CTRL);
  assign wr_stat = reg_wr_i & hit(reg_addr_i, `DSG_OFF_IRQ_STAT);
  assign wr_mask = reg_wr_i & hit(reg_addr_i, `DSG_OFF_IRQ_MASK);

  // run-mode gate register, only the unit bits are storable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_gate_reg0_q <= `DSG_RUN_RESET;
    end else if (wr_run) begin
      run_gate_reg0_q <= reg_wdata_i & `DSG_GATE_WMASK;
    end
  end

  // deep-sleep gate register
  // gate bits start cleared
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deep_sleep_gate_reg0_q <= `DSG_DEEP_RESET & `DSG_GATE_WMASK;
    end else if (wr_deep) begin
      deep_sleep_gate_reg0_q <= reg_wdata_i & `DSG_GATE_WMASK;
    end
  end

  // the documented word reset carries a one in a reserved position; it is
  // kept as a read-only marker that drops on the first write, so the reset
  // word reads back as documented while no gate bit starts enabled
  // reset word marker
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_mark_q <= 1'(`DSG_DEEP_RESET >> `DSG_BIT_RST_MARK);
    end else if (wr_deep) begin
      rst_mark_q <= 1'b0;
    end
  end

  // control register: automatic gating enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_clock_gating_enable_q <= 1'(`DSG_CTRL_RESET >> `DSG_CTRL_ACG_BIT);
    end else if (wr_ctrl) begin
      auto_clock_gating_enable_q <= reg_wdata_i[`DSG_CTRL_ACG_BIT];
    end
  end

  // source of the enables; the deep word is only honoured with auto gating on
  // deep-sleep only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q <= DSG_SRC_RUN;
    end else begin
      case ({deep_sleep_i, auto_clock_gating_enable_q})
        2'b11: src_q <= DSG_SRC_DEEP;
        default: src_q <= DSG_SRC_RUN;
      endcase
    end
  end

  // one gate per unit; enable lags the source by one cycle
  for (genvar u = 0; u < NU; u++) begin : g_unit
    dsg_unit_gate u_gate (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .run_bit_i(gate_bit(run_gate_reg0_q, dsg_unit_t'(u))),
      .deep_bit_i(gate_bit(deep_sleep_gate_reg0_q, dsg_unit_t'(u))),
      .use_deep_i(src_q == DSG_SRC_DEEP),
      .access_i(unit_access_i[u]),
      .clk_en_o(clk_en[u]),
      .fault_o(fault[u])
    );
  end

  // one merged fault answer back to the bus fabric
  // fault to bus
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_fault_q <= 1'b0;
    end else begin
      bus_fault_q <= |fault;
    end
  end

  // sticky fault status, write one to clear; a new fault wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_wdata_i[NU-1:0] : '0)) | fault;
    end
  end

  // interrupt mask, one bit per unit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata_i[NU-1:0];
    end
  end

  // level interrupt; registered, so it follows status by one cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read data, valid the cycle after the strobe only; unmapped reads zero
  // reserved read zero, except deep word bit 6 marker
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      if (hit(reg_addr_i, `DSG_OFF_RUN_GATE)) begin
        rdata_q <= run_gate_reg0_q;
      end else if (hit(reg_addr_i, `DSG_OFF_DEEP_GATE)) begin
        rdata_q <= deep_sleep_gate_reg0_q | (32'(rst_mark_q) << `DSG_BIT_RST_MARK);
      end else if (hit(reg_addr_i, `DSG_OFF_CTRL)) begin
        rdata_q <= 32'(auto_clock_gating_enable_q) << `DSG_CTRL_ACG_BIT;
      end else if (hit(reg_addr_i, `DSG_OFF_STATE)) begin
        rdata_q <= 32'(clk_en)
                 | (32'(deep_sleep_i) << `DSG_STATE_DEEP_BIT)
                 | (32'(src_q == DSG_SRC_DEEP) << `DSG_STATE_SRC_BIT);
      end else if (hit(reg_addr_i, `DSG_OFF_IRQ_STAT)) begin
        rdata_q <= 32'(irq_stat_q);
      end else if (hit(reg_addr_i, `DSG_OFF_IRQ_MASK)) begin
        rdata_q <= 32'(irq_mask_q);
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  // outputs, all from flip-flops
  // unit enables out
  assign pwm_clk_en_o = clk_en[DSG_UNIT_PWM];
  assign adc0_clk_en_o = clk_en[DSG_UNIT_ADC0];
  assign watchdog_gate_o = clk_en[DSG_UNIT_WDOG];
  assign bus_fault_o = bus_fault_q;
  assign irq_o = irq_q;
  assign reg_rdata_o = rdata_q;

endmodule
`default_nettype wire

/* File: verif/dsg_clock_gate_properties.sv */
// port assertions for the deep-sleep clock gate block
`include "dsg_regs.svh"
`default_nettype none
module dsg_clock_gate_properties #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // mode, accesses and results
  input wire logic deep_sleep_i,
  input wire logic [`DSG_NUM_UNITS-1:0] unit_access_i,
  input wire logic pwm_clk_en_o,
  input wire logic adc0_clk_en_o,
  input wire logic watchdog_gate_o,
  input wire logic bus_fault_o,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // no write can land before release, so enables stay off two edges
  rst_gate_a: assert property ($rose(rst_n_i) |-> ##1 !pwm_clk_en_o && !adc0_clk_en_o && !watchdog_gate_o)
    else $error("gate enable set right after reset");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside answer cycle");
  gate_rsvd_a: assert property (reg_rd_i && reg_addr_i == `DSG_OFF_DEEP_GATE |=>
    (reg_rdata_o & ~32'h0011_0048) == 32'h0) else $error("reserved gate bit reads one");
  pwm_fault_a: assert property (unit_access_i[0] && !pwm_clk_en_o |-> ##2 bus_fault_o)
    else $error("gated modulator access without fault");
  adc_fault_a: assert property (unit_access_i[1] && !adc0_clk_en_o |-> ##2 bus_fault_o)
    else $error("gated converter access without fault");
  wdog_fault_a: assert property (unit_access_i[2] && !watchdog_gate_o |-> ##2 bus_fault_o)
    else $error("gated watchdog access without fault");
  fault_cause_a: assert property (bus_fault_o |-> $past(|unit_access_i, 2))
    else $error("fault without access");
  no_fault_a: assert property (unit_access_i == 3'h1 && pwm_clk_en_o |-> ##2 !bus_fault_o)
    else $error("fault on clocked unit");
  // irq is one flop behind status: a mask write shows two edges on, an access three
  irq_rise_a: assert property ($rose(irq_o) |-> $past(reg_wr_i, 2) || $past(|unit_access_i, 3))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(reg_wr_i, 2))
    else $error("interrupt dropped without write");
  cover property (bus_fault_o);
  cover property (irq_o);
  cover property (deep_sleep_i && pwm_clk_en_o);
endmodule

bind dsg_clock_gate dsg_clock_gate_properties #(.ADDR_W(ADDR_W)) i_dsg_clock_gate_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .deep_sleep_i(deep_sleep_i), .unit_access_i(unit_access_i),
  .pwm_clk_en_o(pwm_clk_en_o), .adc0_clk_en_o(adc0_clk_en_o),
  .watchdog_gate_o(watchdog_gate_o), .bus_fault_o(bus_fault_o), .irq_o(irq_o));
`default_nettype wire

/* File: verif/test_dsg_clock_gate.sv */
// self-checking bench for the deep-sleep clock gate block
`include "dsg_regs.svh"
`default_nettype none
module test_dsg_clock_gate;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic [2:0] unit_access_i = 3'h0;
  logic [31:0] reg_rdata_o;
  logic pwm_clk_en_o, adc0_clk_en_o, watchdog_gate_o, bus_fault_o, irq_o;
  int err_total = 0;
  int tests_run = 0;
  // word written to the deep gate, word read back
  logic [31:0] rows [5][2] = '{'{32'hFFFF_FFFF, 32'h0011_0008},
    '{32'h0010_0000, 32'h0010_0000}, '{32'h0001_0040, 32'h0001_0000},
    '{32'hFFEE_FFFF, 32'h0000_0008}, '{32'h0000_0000, 32'h0000_0000}};

  dsg_clock_gate i_dsg_clock_gate (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .deep_sleep_i(deep_sleep_i),
    .unit_access_i(unit_access_i), .pwm_clk_en_o(pwm_clk_en_o),
    .adc0_clk_en_o(adc0_clk_en_o), .watchdog_gate_o(watchdog_gate_o),
    .bus_fault_o(bus_fault_o), .irq_o(irq_o));

  always #5 ref_clk_i = ~ref_clk_i;

  task results;
    $display("counts: %0d mismatches in %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_o);
  endtask

  // one access pulse; the fault pulse stands only in the cycle after the next edge
  task hit(input int u, input logic exp);
    @(posedge ref_clk_i);
    unit_access_i <= 3'h1 << u;
    @(posedge ref_clk_i);
    unit_access_i <= 3'h0;
    tick(1);
    chk("bus fault", {31'h0, exp}, {31'h0, bus_fault_o});
  endtask

  task ens(input logic [2:0] exp);
    chk("enables", {29'h0, exp}, {29'h0, watchdog_gate_o, adc0_clk_en_o, pwm_clk_en_o});
  endtask

  // a hang is cut off well past the expected run of some 140 cycles
  initial begin
    #20000;
    err_total++;
    results;
  end

  initial begin
    logic [2:0] en;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    ens(3'h0);
    rd(`DSG_OFF_DEEP_GATE, `DSG_DEEP_RESET, "deep reset word");
    rd(12'h1FC, 32'h0, "unmapped read");
    rd(`DSG_OFF_CTRL, 32'h0, "ctrl reset");
    wr(`DSG_OFF_CTRL, 32'h1);
    deep_sleep_i <= 1'b1;
    // ordinary rows: readback, enables and faults per unit in deep-sleep
    for (int i = 0; i < 5; i++) begin
      wr(`DSG_OFF_DEEP_GATE, rows[i][0]);
      rd(`DSG_OFF_DEEP_GATE, rows[i][1], "deep word");
      tick(1);
      en = {rows[i][1][`DSG_BIT_WDOG], rows[i][1][`DSG_BIT_ADC0], rows[i][1][`DSG_BIT_PWM]};
      ens(en);
      for (int u = 0; u < 3; u++) hit(u, ~en[u]);
    end
    // source selection: deep word only in deep-sleep with auto gating
    wr(`DSG_OFF_IRQ_STAT, 32'h7);
    wr(`DSG_OFF_RUN_GATE, 32'h0000_0008);
    wr(`DSG_OFF_DEEP_GATE, 32'h0010_0000);
    tick(2);
    ens(3'h1);
    rd(`DSG_OFF_STATE, 32'h0000_0301, "state deep");
    @(posedge ref_clk_i);
    deep_sleep_i <= 1'b0;
    tick(3);
    ens(3'h4);
    rd(`DSG_OFF_STATE, 32'h0000_0004, "state run");
    rd(`DSG_OFF_RUN_GATE, 32'h0000_0008, "run word");
    @(posedge ref_clk_i);
    deep_sleep_i <= 1'b1;
    rd(`DSG_OFF_CTRL, 32'h1, "ctrl word");
    wr(`DSG_OFF_CTRL, 32'h0);
    tick(2);
    ens(3'h4);
    // interrupt: raise, read, clear, then masked out
    wr(`DSG_OFF_IRQ_MASK, 32'h1);
    rd(`DSG_OFF_IRQ_MASK, 32'h1, "irq mask");
    hit(0, 1'b1);
    tick(1);
    chk("irq set", 32'h1, {31'h0, irq_o});
    rd(`DSG_OFF_IRQ_STAT, 32'h1, "irq status");
    hit(2, 1'b0);
    wr(`DSG_OFF_IRQ_STAT, 32'h1);
    tick(2);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wr(`DSG_OFF_IRQ_MASK, 32'h0);
    hit(1, 1'b1);
    tick(1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    // mid-run reset: enables drop at once, marker and status back to reset
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    tick(1);
    ens(3'h0);
    chk("irq in reset", 32'h0, {31'h0, irq_o});
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    ens(3'h0);
    rd(`DSG_OFF_DEEP_GATE, `DSG_DEEP_RESET, "deep word after reset");
    rd(`DSG_OFF_RUN_GATE, 32'h0, "run word after reset");
    rd(`DSG_OFF_IRQ_STAT, 32'h0, "irq status after reset");
    results;
  end
endmodule
`default_nettype wire
